// ===== logic/cdcc_pkg.sv
// Constants shared by the co-directional converter control block.
// Assumes a 200 MHz system clock and a 64 kbps line.
package cdcc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned LINE_BPS    = 64_000;
  // Whole clock cycles per line bit (longest time, rounded down)
  localparam int unsigned BIT_CYCLES  = CLK_HZ / LINE_BPS;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned PHASE_W     = 12;

  // ----------------------------------------------------------------
  // APB register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_CONFIG  = 8'h00;
  localparam logic [7:0]  OFF_TEST    = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_ERRCNT  = 8'h0C;

  // Configuration fields
  localparam int unsigned CFG_CLK_LOW      = 0;
  localparam int unsigned CFG_CLK_HIGH     = 1;
  localparam int unsigned CFG_SAMPLE_EXT   = 2;
  localparam int unsigned CFG_RLOOP_DIS    = 3;
  localparam int unsigned CFG_PANEL_DIS    = 4;
  localparam int unsigned CFG_TLOOP_DIS    = 5;
  localparam int unsigned CFG_W            = 6;
  localparam logic [5:0]  CFG_RESET        = 6'h00;

  // Front-panel test control fields
  localparam int unsigned TST_LOCAL_LOOP   = 0;
  localparam int unsigned TST_REMOTE_LOOP  = 1;
  localparam int unsigned TST_PATTERN      = 2;
  localparam int unsigned TST_PATTERN_ERR  = 3;
  localparam int unsigned TST_W            = 4;
  localparam logic [3:0]  TST_RESET        = 4'h0;

  // Status fields
  localparam int unsigned STS_LOCAL_LOOP   = 0;
  localparam int unsigned STS_REMOTE_LOOP  = 1;
  localparam int unsigned STS_PATTERN      = 2;
  localparam int unsigned STS_SYNC         = 3;
  localparam int unsigned STS_CLK_LSB      = 4;

  // ----------------------------------------------------------------
  // Test pattern: 511-bit sequence, x^9 + x^5 + 1
  // ----------------------------------------------------------------
  localparam int unsigned PRBS_LEN   = 9;
  localparam int unsigned PRBS_TAP   = 5;
  localparam logic [8:0]  PRBS_SEED  = 9'h1FF;
  localparam int unsigned ERR_W      = 16;
  localparam int unsigned SYNC_RUN   = 16;

  // Transmit clock source, encoded as {high, low} switch bits
  typedef enum logic [1:0] {
    CDCC_SRC_INTERNAL,
    CDCC_SRC_TERMINAL,
    CDCC_SRC_LINE_NORMAL,
    CDCC_SRC_LINE_CAMPUS
  } cdcc_src_t;

endpackage : cdcc_pkg

// ===== logic/cdcc_prbs.sv
// Pattern generator and self-synchronising checker for the bit error test.
// Assumes ticks arrive at line rate, far apart compared with clk_sys.
module cdcc_prbs (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  cdcc_prbs_if.engine pif
);
  import cdcc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [8:0]        gen_reg,  gen_next;
  logic [8:0]        wrap_reg, wrap_next;
  logic [8:0]        chk_reg,  chk_next;
  logic [4:0]        run_reg,  run_next;
  logic [ERR_W-1:0]  err_reg,  err_next;
  logic              bit_reg,  bit_next;
  logic              gen_fb;
  logic              chk_miss;

  // Next values; one forced error per sequence in the erroring variant
  always_comb begin
    gen_fb    = gen_reg[PRBS_LEN-1] ^ gen_reg[PRBS_TAP-1];
    chk_miss  = pif.rx_bit != (chk_reg[PRBS_LEN-1] ^ chk_reg[PRBS_TAP-1]);
    gen_next  = gen_reg;
    wrap_next = wrap_reg;
    bit_next  = bit_reg;
    chk_next  = chk_reg;
    run_next  = run_reg;
    err_next  = pif.err_clear ? '0 : err_reg;   // New error beats a clear
    if (pif.tx_tick) begin
      gen_next  = {gen_reg[7:0], gen_fb};
      wrap_next = (wrap_reg == 9'h1FE) ? 9'h000 : wrap_reg + 9'h001;
      bit_next  = gen_fb ^ (pif.err_insert && wrap_reg == 9'h000);
    end
    if (pif.rx_tick) begin
      chk_next = {chk_reg[7:0], pif.rx_bit};
      if (chk_miss) begin
        run_next = 5'h00;
        // Errors only count once locked, so lock-up noise is not logged
        if (run_reg == 5'(SYNC_RUN) && err_next != '1) begin
          err_next = err_next + 16'h0001;
        end
      end else if (run_reg != 5'(SYNC_RUN)) begin
        run_next = run_reg + 5'h01;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gen_reg  <= PRBS_SEED;
      wrap_reg <= 9'h000;
      bit_reg  <= 1'b0;
      chk_reg  <= 9'h000;
      run_reg  <= 5'h00;
      err_reg  <= '0;
    end else begin
      gen_reg  <= gen_next;
      wrap_reg <= wrap_next;
      bit_reg  <= bit_next;
      chk_reg  <= chk_next;
      run_reg  <= run_next;
      err_reg  <= err_next;
    end
  end

  assign pif.tx_bit    = bit_reg;
  assign pif.sync      = run_reg == 5'(SYNC_RUN);
  assign pif.err_count = err_reg;

endmodule : cdcc_prbs

// ===== logic/cdcc_prbs_if.sv
// Link between the control core and its test pattern engine.
// Both ends run on clk_sys; ticks are one-cycle pulses.
interface cdcc_prbs_if;
  import cdcc_pkg::*;
  logic              tx_tick;     // Advance generator one bit
  logic              rx_tick;     // Take one received bit
  logic              rx_bit;      // Received line bit
  logic              err_insert;  // Error-inserting variant selected
  logic              err_clear;   // Clear error counter
  logic              tx_bit;      // Next pattern bit
  logic              sync;        // Checker locked
  logic [ERR_W-1:0]  err_count;   // Bit errors seen

  modport core   (output tx_tick, rx_tick, rx_bit, err_insert, err_clear,
                  input  tx_bit, sync, err_count);
  modport engine (input  tx_tick, rx_tick, rx_bit, err_insert, err_clear,
                  output tx_bit, sync, err_count);
endinterface : cdcc_prbs_if

// ===== logic/cdcc_top.sv
// Control core of the terminal to 64 kbps co-directional line converter.
// Assumes all pin inputs are asynchronous to clk_sys; software uses APB.

module cdcc_top (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [cdcc_pkg::ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  terminal_external_clock,
  input  wire logic                  terminal_transmit_data,
  input  wire logic                  terminal_loop_request,
  input  wire logic                  line_recovered_clock,
  input  wire logic                  line_rx_pos,
  input  wire logic                  line_rx_neg,
  input  wire logic                  far_end_loop_request,
  output logic                       device_transmit_clock,
  output logic                       terminal_receive_data,
  output logic                       line_tx_pos,
  output logic                       line_tx_neg,
  output logic                       remote_loop_request_out,
  output logic                       local_loop_active,
  output logic                       remote_loop_active
);
  import cdcc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 7;
  logic [NPIN-1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic ext_clk_s, td_s, tloop_s, rec_clk_s, rx_pos_s, rx_neg_s, far_req_s;

  // Two flops per pin; prev copy reads only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= {far_end_loop_request, line_rx_neg, line_rx_pos,
                       line_recovered_clock, terminal_loop_request,
                       terminal_transmit_data, terminal_external_clock};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign {far_req_s, rx_neg_s, rx_pos_s, rec_clk_s, tloop_s, td_s, ext_clk_s} = pin_sync_reg;

  // ----------------------------------------------------------------
  // APB slave and registers
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_reg,   cfg_next;
  logic [TST_W-1:0] tst_reg,   tst_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             ready_reg, ready_next;
  logic             err_reg,   err_next;
  logic             err_clr;
  logic [31:0]      status_word;
  logic             access;
  cdcc_prbs_if      pif ();

  // Each access waits one cycle so all answers come from flops
  always_comb begin
    access     = psel && penable && !ready_reg;
    cfg_next   = cfg_reg;
    tst_next   = tst_reg;
    rdata_next = 32'h0000_0000;
    ready_next = access;
    err_next   = 1'b0;
    err_clr    = 1'b0;
    if (access) begin
      case (paddr)
        OFF_CONFIG: rdata_next = {26'h0, cfg_reg};
        OFF_TEST:   rdata_next = {28'h0, tst_reg};
        OFF_STATUS: rdata_next = status_word;
        OFF_ERRCNT: rdata_next = {16'h0, pif.err_count};
        default:    err_next   = 1'b1;
      endcase
    end
    // Writes land only at the edge where the master sees pready high
    if (psel && penable && ready_reg && pwrite) begin
      case (paddr)
        OFF_CONFIG: cfg_next = pwdata[CFG_W-1:0];
        OFF_TEST:   tst_next = pwdata[TST_W-1:0];
        OFF_ERRCNT: err_clr  = 1'b1;
        default:    err_clr  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg   <= CFG_RESET;
      tst_reg   <= TST_RESET;
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      cfg_reg   <= cfg_next;
      tst_reg   <= tst_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // Test mode gating
  // ----------------------------------------------------------------
  cdcc_src_t src;
  logic panel_on, local_loop, remote_answer, pattern_on;

  always_comb begin
    src           = cdcc_src_t'({cfg_reg[CFG_CLK_HIGH], cfg_reg[CFG_CLK_LOW]});
    panel_on      = !cfg_reg[CFG_PANEL_DIS];
    local_loop    = (panel_on && tst_reg[TST_LOCAL_LOOP])
                  || (!cfg_reg[CFG_TLOOP_DIS] && tloop_s);
    remote_answer = !cfg_reg[CFG_RLOOP_DIS] && far_req_s;
    pattern_on    = panel_on && (tst_reg[TST_PATTERN] || tst_reg[TST_PATTERN_ERR]);
    status_word   = {26'h0, src, pif.sync, pattern_on, remote_answer, local_loop};
  end

  // ----------------------------------------------------------------
  // Transmit clock: phase accumulator, steered by the line clock
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic               txclk_reg, txclk_next;
  logic               ref_edge, rec_rise, ext_rise, tx_rise, sample_edge;
  logic [PHASE_W:0]   phase_inc;

  // Line modes nudge phase by one cycle per reference edge, so jitter on
  // the recovered clock is filtered instead of passed to the transmitter
  always_comb begin
    rec_rise  = rec_clk_s && !pin_prev_reg[3];
    ext_rise  = ext_clk_s && !pin_prev_reg[0];
    ref_edge  = (src == CDCC_SRC_LINE_CAMPUS) ? (!rec_clk_s && pin_prev_reg[3]) : rec_rise;
    phase_inc = {1'b0, phase_reg} + 13'h0001;
    if (src == CDCC_SRC_LINE_NORMAL || src == CDCC_SRC_LINE_CAMPUS) begin
      if (ref_edge && phase_reg != '0) begin
        if (phase_reg < PHASE_W'(HALF_CYCLES)) phase_inc = {1'b0, phase_reg};
        else phase_inc = {1'b0, phase_reg} + 13'h0002;
      end
    end
    phase_next = (phase_inc >= 13'(BIT_CYCLES)) ? '0 : phase_inc[PHASE_W-1:0];
    case (src)
      CDCC_SRC_TERMINAL: txclk_next = ext_clk_s;
      default:           txclk_next = phase_next < PHASE_W'(HALF_CYCLES);
    endcase
    tx_rise     = txclk_next && !txclk_reg;
    sample_edge = cfg_reg[CFG_SAMPLE_EXT] ? ext_rise : tx_rise;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= '0;
      txclk_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      txclk_reg <= txclk_next;
    end
  end

  // ----------------------------------------------------------------
  // Data path: sampling, loops, pattern and AMI coding
  // ----------------------------------------------------------------
  logic td_reg,    td_next;
  logic rx_reg,    rx_next;
  logic trx_reg,   trx_next;
  logic pos_reg,   pos_next;
  logic neg_reg,   neg_next;
  logic pol_reg,   pol_next;
  logic rloop_reg, rloop_next;
  logic lloop_reg, lloop_next;
  logic rreq_reg,  rreq_next;
  logic line_bit;

  // Line bits go out on the transmit clock; receive bits on the line clock
  always_comb begin
    td_next    = sample_edge ? td_s : td_reg;
    rx_next    = rec_rise ? (rx_pos_s || rx_neg_s) : rx_reg;
    line_bit   = pattern_on ? pif.tx_bit : (remote_answer ? rx_reg : td_reg);
    trx_next   = trx_reg;
    pos_next   = pos_reg;
    neg_next   = neg_reg;
    pol_next   = pol_reg;
    if (tx_rise) begin
      trx_next = local_loop ? td_reg : rx_reg;
      pos_next = line_bit && !pol_reg;
      neg_next = line_bit && pol_reg;
      pol_next = pol_reg ^ line_bit;
    end
    rloop_next = remote_answer;
    lloop_next = local_loop;
    rreq_next  = panel_on && tst_reg[TST_REMOTE_LOOP];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      td_reg    <= 1'b0;
      rx_reg    <= 1'b0;
      trx_reg   <= 1'b0;
      pos_reg   <= 1'b0;
      neg_reg   <= 1'b0;
      pol_reg   <= 1'b0;
      rloop_reg <= 1'b0;
      lloop_reg <= 1'b0;
      rreq_reg  <= 1'b0;
    end else begin
      td_reg    <= td_next;
      rx_reg    <= rx_next;
      trx_reg   <= trx_next;
      pos_reg   <= pos_next;
      neg_reg   <= neg_next;
      pol_reg   <= pol_next;
      rloop_reg <= rloop_next;
      lloop_reg <= lloop_next;
      rreq_reg  <= rreq_next;
    end
  end

  // Pattern engine hookup
  assign pif.tx_tick    = tx_rise && pattern_on;
  assign pif.rx_tick    = rec_rise && pattern_on;
  assign pif.rx_bit     = rx_pos_s || rx_neg_s;
  assign pif.err_insert = tst_reg[TST_PATTERN_ERR];
  assign pif.err_clear  = err_clr;

  cdcc_prbs u_prbs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pif     (pif)
  );

  // Outputs, all from flops
  assign prdata                  = rdata_reg;
  assign pready                  = ready_reg;
  assign pslverr                 = err_reg;
  assign device_transmit_clock   = txclk_reg;
  assign terminal_receive_data   = trx_reg;
  assign line_tx_pos             = pos_reg;
  assign line_tx_neg             = neg_reg;
  assign remote_loop_request_out = rreq_reg;
  assign local_loop_active       = lloop_reg;
  assign remote_loop_active      = rloop_reg;

endmodule : cdcc_top

// ===== tb/cdcc_bench.sv
// Self-checking bench for the converter control core.
// Assumes the far-side model supplies the terminal clock and loops the line.
module cdcc_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cdcc_pkg::*;

  logic        clk_sys, rst_n, psel, penable, pwrite, run, td, tl_req, fe_req, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, ext_clk, ln_clk, rx_p, rx_n, txc, trd, tx_p, tx_n;
  logic        rq_out, ll_act, rl_act;
  int          n_errors, comparisons;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  cdcc_top dut (
    .clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .terminal_external_clock(ext_clk), .terminal_transmit_data(td),
    .terminal_loop_request(tl_req), .line_recovered_clock(ln_clk), .line_rx_pos(rx_p),
    .line_rx_neg(rx_n), .far_end_loop_request(fe_req), .device_transmit_clock(txc),
    .terminal_receive_data(trd), .line_tx_pos(tx_p), .line_tx_neg(tx_n),
    .remote_loop_request_out(rq_out), .local_loop_active(ll_act), .remote_loop_active(rl_act)
  );
  cdcc_line_model far_end (
    .run, .line_tx_pos(tx_p), .line_tx_neg(tx_n), .terminal_external_clock(ext_clk),
    .line_recovered_clock(ln_clk), .line_rx_pos(rx_p), .line_rx_neg(rx_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; an idle cycle after it keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      conclude();
    end
    @(posedge clk_sys);
  endtask : apb

  task automatic cfg_test(input logic [31:0] c, input logic [31:0] t);
    apb(1'b1, OFF_CONFIG, c);
    apb(1'b1, OFF_TEST, t);
    repeat (12) @(posedge clk_sys);
  endtask : cfg_test

  // Cycles up to the next rise of the transmit clock, bounded
  task automatic wait_rise(output int n);
    logic p;
    n = 0;
    do begin
      p = txc;
      @(posedge clk_sys);
      n++;
    end while (!(p === 1'b0 && txc === 1'b1) && n < 8000);
    if (n >= 8000) begin
      n_errors++;
      conclude();
    end
  endtask : wait_rise

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, OFF_CONFIG, 32'h0);
    chk("config_reset", 32'h0, rd);
    apb(1'b0, OFF_TEST, 32'h0);
    chk("test_reset", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status_ro", 32'h0, rd);
  endtask : t_regs

  task automatic t_clocks;
    int c;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_CONFIG, 32'(m));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("clock_source", 32'(m), (rd >> STS_CLK_LSB) & 32'h3);
    end
    apb(1'b1, OFF_CONFIG, 32'h0);
    wait_rise(c);
    wait_rise(c);
    chk("bit_cycles", BIT_CYCLES, 32'(c));
  endtask : t_clocks

  task automatic t_loops;
    cfg_test(32'h10, 32'h1);
    chk("panel_off_local", 32'h0, 32'(ll_act));
    cfg_test(32'h00, 32'h1);
    chk("panel_on_local", 32'h1, 32'(ll_act));
    cfg_test(32'h00, 32'h2);
    chk("panel_on_request", 32'h1, 32'(rq_out));
    cfg_test(32'h10, 32'h2);
    chk("panel_off_request", 32'h0, 32'(rq_out));
    fe_req <= 1'b1;
    cfg_test(32'h00, 32'h0);
    chk("far_loop_on", 32'h1, 32'(rl_act));
    cfg_test(32'h08, 32'h0);
    chk("far_loop_off", 32'h0, 32'(rl_act));
    fe_req <= 1'b0;
    tl_req <= 1'b1;
    cfg_test(32'h00, 32'h0);
    chk("term_loop_on", 32'h1, 32'(ll_act));
    cfg_test(32'h20, 32'h0);
    chk("term_loop_off", 32'h0, 32'(ll_act));
    tl_req <= 1'b0;
  endtask : t_loops

  task automatic t_term;
    run <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      cfg_test(s ? 32'h5 : 32'h1, 32'h1);
      for (int b = 0; b < 4; b++) begin
        td <= b[0];
        repeat (100) @(posedge clk_sys);
        chk("loop_data", 32'(b[0]), 32'(trd));
      end
    end
  endtask : t_term

  task automatic t_ami;
    int c;
    logic [1:0] prev;
    cfg_test(32'h1, 32'h0);
    td <= 1'b1;
    repeat (2) wait_rise(c);
    repeat (5) @(posedge clk_sys);
    prev = {tx_p, tx_n};
    chk("mark_onehot", 32'h1, 32'($countones(prev)));
    for (int i = 0; i < 4; i++) begin
      wait_rise(c);
      repeat (5) @(posedge clk_sys);
      chk("mark_alternate", 32'({prev[0], prev[1]}), 32'({tx_p, tx_n}));
      prev = {tx_p, tx_n};
    end
    td <= 1'b0;
    repeat (3) wait_rise(c);
    repeat (5) @(posedge clk_sys);
    chk("space", 32'h0, 32'({tx_p, tx_n}));
  endtask : t_ami

  task automatic t_pattern;
    cfg_test(32'h11, 32'h4);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("pattern_blocked", 32'h0, 32'(rd[STS_PATTERN]));
    cfg_test(32'h01, 32'h4);
    repeat (1500) @(posedge clk_sys);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("pattern_sync", 32'h3, (rd >> STS_PATTERN) & 32'h3);
    apb(1'b0, OFF_ERRCNT, 32'h0);
    chk("clean_errors", 32'h0, rd);
    cfg_test(32'h01, 32'hC);
    repeat (27500) @(posedge clk_sys);
    apb(1'b0, OFF_ERRCNT, 32'h0);
    chk("errors_seen", 32'h1, 32'(rd != 32'h0));
    cfg_test(32'h01, 32'h4);
    apb(1'b1, OFF_ERRCNT, 32'h0);
    apb(1'b0, OFF_ERRCNT, 32'h0);
    chk("errors_cleared", 32'h0, rd);
    cfg_test(32'h01, 32'h0);
  endtask : t_pattern

  // Main sequence: reset, then every scenario in turn
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, run, td, tl_req, fe_req} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_clocks();
    t_loops();
    t_term();
    t_ami();
    t_pattern();
    conclude();
  end
endmodule : cdcc_bench

// ===== tb/cdcc_line_model.sv
// Far side: terminal clock source plus a line looped back at the far end.
// Assumes run is held by the bench; clocks stand still low while idle.
module cdcc_line_model (
  input  wire logic run,
  input  wire logic line_tx_pos,
  input  wire logic line_tx_neg,
  output logic      terminal_external_clock,
  output logic      line_recovered_clock,
  output logic      line_rx_pos,
  output logic      line_rx_neg
);
  timeunit 1ns;
  timeprecision 100ps;

  // Terminal clock, 125 ns period, offset so edges miss clk_sys edges
  initial begin
    terminal_external_clock = 1'b0;
    #1.2;
    forever begin
      #62.5;
      terminal_external_clock = run ? ~terminal_external_clock : 1'b0;
    end
  end

  // Line clock in antiphase, so received bits are taken mid-cell
  assign line_recovered_clock = run & ~terminal_external_clock;
  // Far end echoes both rails; polarity checks stay on our transmit side
  assign line_rx_pos = line_tx_pos;
  assign line_rx_neg = line_tx_neg;
endmodule : cdcc_line_model

// ===== tb/cdcc_top_asserts.sv
// Checker for the converter control core, seeing only its top ports.
// Assumes APB writes land at the edge where pready is seen high.
module cdcc_top_asserts (
  input wire logic                         clk_sys,
  input wire logic                         rst_n,
  input wire logic [cdcc_pkg::ADDR_W-1:0]  paddr,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         terminal_loop_request,
  input wire logic                         far_end_loop_request,
  input wire logic                         device_transmit_clock,
  input wire logic                         terminal_receive_data,
  input wire logic                         line_tx_pos,
  input wire logic                         line_tx_neg,
  input wire logic                         remote_loop_request_out,
  input wire logic                         local_loop_active,
  input wire logic                         remote_loop_active
);
  timeunit 1ns;
  timeprecision 100ps;
  import cdcc_pkg::*;

  logic [5:0]  cfg_q;
  logic [3:0]  tst_q;
  logic [2:0]  d_q;
  logic [15:0] cnt_q;
  logic        last_pos_q;
  logic        wr_ok;
  logic        ll_cause;
  logic        rl_cause;
  logic        rq_cause;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  // Only completed, accepted writes count; refused ones leave no trace
  assign wr_ok    = psel && penable && pready && pwrite && !pslverr;
  assign ll_cause = (terminal_loop_request && !cfg_q[CFG_TLOOP_DIS])
                 || (tst_q[TST_LOCAL_LOOP] && !cfg_q[CFG_PANEL_DIS]);
  assign rl_cause = far_end_loop_request && !cfg_q[CFG_RLOOP_DIS];
  assign rq_cause = tst_q[TST_REMOTE_LOOP] && !cfg_q[CFG_PANEL_DIS];

  // Registers, last mark polarity and internal bit-time counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q      <= CFG_RESET;
      tst_q      <= TST_RESET;
      d_q        <= 3'h0;
      cnt_q      <= 16'h0;
      last_pos_q <= 1'b0;
    end else begin
      if (wr_ok && paddr == OFF_CONFIG) begin
        cfg_q <= pwdata[5:0];
      end
      if (wr_ok && paddr == OFF_TEST) begin
        tst_q <= pwdata[3:0];
      end
      if ((line_tx_pos && !d_q[1]) || (line_tx_neg && !d_q[0])) begin
        last_pos_q <= line_tx_pos;
      end
      d_q   <= {device_transmit_clock, line_tx_pos, line_tx_neg};
      cnt_q <= ((device_transmit_clock && !d_q[2]) || cfg_q[1:0] != 2'h0) ? 16'h0
             : cnt_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rails_excl; !(line_tx_pos && line_tx_neg); endproperty
  a_rails_excl: assert property (p_rails_excl) else $error("both line rails high");
  property p_ami_alt; ($rose(line_tx_pos) || $rose(line_tx_neg)) |-> line_tx_pos != last_pos_q;
  endproperty
  a_ami_alt: assert property (p_ami_alt) else $error("mark polarity repeated");
  property p_rail_edge;
    ($changed(line_tx_pos) || $changed(line_tx_neg)) |-> $rose(device_transmit_clock);
  endproperty
  a_rail_edge: assert property (p_rail_edge) else $error("line rail moved off clock");
  property p_rx_edge; $changed(terminal_receive_data) |-> $rose(device_transmit_clock);
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("receive data moved off clock");
  property p_local_loop; ($stable(ll_cause))[*8] |-> local_loop_active == ll_cause; endproperty
  a_local_loop: assert property (p_local_loop) else $error("local loop state wrong");
  property p_remote_loop; ($stable(rl_cause))[*8] |-> remote_loop_active == rl_cause;
  endproperty
  a_remote_loop: assert property (p_remote_loop) else $error("remote loop answer wrong");
  property p_remote_req;
    ($stable(rq_cause))[*4] |-> remote_loop_request_out == rq_cause;
  endproperty
  a_remote_req: assert property (p_remote_req) else $error("remote request wrong");
  // Internal clock may never stretch past one bit time
  property p_int_rate; cnt_q < BIT_CYCLES; endproperty
  a_int_rate: assert property (p_int_rate) else $error("internal bit time too long");

  c_local: cover property ($rose(local_loop_active));
  c_remote: cover property ($rose(remote_loop_active));
  c_neg_mark: cover property ($rose(line_tx_neg));
endmodule : cdcc_top_asserts

bind cdcc_top cdcc_top_asserts u_asserts (
  .clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .terminal_loop_request, .far_end_loop_request, .device_transmit_clock,
  .terminal_receive_data, .line_tx_pos, .line_tx_neg, .remote_loop_request_out,
  .local_loop_active, .remote_loop_active
);
